// [src/see_eeprom.sv]
// Operation
// - receiver pulls data low on ninth clock
// - acknowledge start plus matching slave address
// - acknowledge every byte while write-addressed
// - send eight bits, stop on missing ack
// - byte write loads word address pointer
// - stop starts programming, ignore bus meanwhile
// - up to sixteen bytes per page write
// - page write increments low address bits
// - extra page bytes wrap and overwrite
// - program whole buffered page in one cycle
// - no ack while programming, ack after
// - write protect refuses first data byte
// - read direction bit one, three forms
// - counter holds last address plus one
// - counter wraps to zero past top
// - master ends read with nack, stop
// - random read via dummy write, restart
// - master ack requests next read byte
// - read increment spans all address bits
// - type code, high bits, direction bit
// - start and stop seen while clock high
`timescale 1ns/1ns
`default_nettype none
module see_eeprom (
	input wire logic clk_sys,
	input wire logic rst_b,
	input wire logic wp,
	see_i2c_if.slave bus,
	output logic busy
);
	import see_pkg::*;
	typedef enum logic [5:0] {
		SS_IDLE = 6'h01,
		SS_RX = 6'h02,
		SS_ACK = 6'h04,
		SS_TX = 6'h08,
		SS_RACK = 6'h10,
		SS_WAIT = 6'h20
	} see_sstate_type;
	logic [7:0] mem [MEM_DEPTH];
	logic [7:0] pbuf [2**PAGE_W];
	logic [2:0] sync1, sync2;
	logic scl_d, sda_d, scl_s, sda_s, wp_s;
	logic rise, fall, start_c, stop_c;
	see_sstate_type state, next_state;
	logic [1:0] kind, next_kind;
	logic [3:0] cnt, next_cnt;
	logic [7:0] sh, next_sh;
	logic [ADDR_W-1:0] ptr, next_ptr;
	logic [SA_HI_W-1:0] hi, next_hi;
	logic rw, next_rw, oe, next_oe, buf_we;
	logic [2**PAGE_W-1:0] mask, next_mask;
	logic next_busy;
	logic [PAGE_W:0] idx, next_idx;
	logic [9:0] pcnt, next_pcnt;

	// ----------------------------------------------------------------
	// pin synchronisers and bus conditions
	// ----------------------------------------------------------------
	always_ff @(posedge clk_sys or negedge rst_b)
	begin
		if (!rst_b)
		begin
			sync1 <= 3'h3;
			sync2 <= 3'h3;
			scl_d <= 1'b1;
			sda_d <= 1'b1;
		end
		else
		begin
			sync1 <= {wp, bus.sda, bus.scl};
			sync2 <= sync1;
			scl_d <= sync2[0];
			sda_d <= sync2[1];
		end
	end
	// edges of the synchronised lines
	always_comb
	begin
		scl_s = sync2[0];
		sda_s = sync2[1];
		wp_s = sync2[2];
		rise = scl_s & ~scl_d;
		fall = ~scl_s & scl_d;
		start_c = scl_s & scl_d & sda_d & ~sda_s;
		stop_c = scl_s & scl_d & ~sda_d & sda_s;
	end

	// ----------------------------------------------------------------
	// protocol engine
	// ----------------------------------------------------------------
	always_comb
	begin
		next_state = state;
		next_kind = kind;
		next_cnt = cnt;
		next_sh = sh;
		next_ptr = ptr;
		next_hi = hi;
		next_rw = rw;
		next_mask = mask;
		buf_we = 1'b0;
		if (start_c)
		begin
			next_cnt = 4'h0;
			next_kind = KIND_SADDR;
			next_state = busy ? SS_WAIT : SS_RX;
			if (!busy)
				next_mask = '0;
		end
		else if (stop_c)
			next_state = SS_IDLE;
		else
		begin
			case (state)
				SS_RX:
				begin
					if (rise)
					begin
						next_sh = {sh[6:0], sda_s};
						next_cnt = cnt + 4'h1;
					end
					else if (fall && cnt == BYTE_BITS)
					begin
						next_state = SS_ACK;
						case (kind)
							KIND_SADDR:
							begin
								if (sh[SA_TYPE_LSB +: 4] != DEV_TYPE)
									next_state = SS_WAIT;
								next_rw = sh[SA_RW_BIT];
								next_hi = sh[SA_HI_LSB +: SA_HI_W];
								next_kind = KIND_WADDR;
							end
							KIND_WADDR:
							begin
								next_ptr = {hi, sh};
								next_kind = KIND_DATA;
							end
							default:
							begin
								if (wp_s)
									next_state = SS_WAIT;
								else
								begin
									buf_we = 1'b1;
									next_mask[ptr[PAGE_W-1:0]] = 1'b1;
									next_ptr = {ptr[ADDR_W-1:PAGE_W], ptr[PAGE_W-1:0] + 4'h1};
								end
							end
						endcase
					end
				end
				SS_ACK:
				begin
					if (fall)
					begin
						next_cnt = 4'h0;
						if (rw)
						begin
							next_state = SS_TX;
							next_sh = mem[ptr];
							next_ptr = ptr + 11'h001;
						end
						else
							next_state = SS_RX;
					end
				end
				SS_TX:
				begin
					if (rise)
						next_cnt = cnt + 4'h1;
					else if (fall)
					begin
						if (cnt == BYTE_BITS)
							next_state = SS_RACK;
						else
							next_sh = {sh[6:0], 1'b0};
					end
				end
				SS_RACK:
				begin
					if (rise && sda_s)
						next_state = SS_WAIT;
					else if (fall)
					begin
						next_state = SS_TX;
						next_cnt = 4'h0;
						next_sh = mem[ptr];
						next_ptr = ptr + 11'h001;
					end
				end
				default: next_state = state;
			endcase
		end
		// drive low for ack or for a zero data bit
		next_oe = (next_state == SS_ACK) || (next_state == SS_TX && !next_sh[7]);
	end

	// ----------------------------------------------------------------
	// internal programming cycle
	// ----------------------------------------------------------------
	always_comb
	begin
		next_busy = busy;
		next_idx = idx;
		next_pcnt = pcnt;
		if (!busy)
		begin
			if (stop_c && |mask && state != SS_IDLE)
			begin
				next_busy = 1'b1;
				next_idx = '0;
				next_pcnt = '0;
			end
		end
		else
		begin
			if (!idx[PAGE_W])
				next_idx = idx + 5'h01;
			next_pcnt = pcnt + 10'h001;
			if (pcnt == WR_LAST)
				next_busy = 1'b0;
		end
	end
	always_ff @(posedge clk_sys or negedge rst_b)
	begin
		if (!rst_b)
		begin
			state <= SS_IDLE;
			kind <= KIND_SADDR;
			cnt <= 4'h0;
			sh <= 8'h00;
			ptr <= '0;
			hi <= '0;
			rw <= 1'b0;
			oe <= 1'b0;
			mask <= '0;
			busy <= 1'b0;
			idx <= '0;
			pcnt <= '0;
		end
		else
		begin
			state <= next_state;
			kind <= next_kind;
			cnt <= next_cnt;
			sh <= next_sh;
			ptr <= next_ptr;
			hi <= next_hi;
			rw <= next_rw;
			oe <= next_oe;
			mask <= (busy && !next_busy) ? '0 : next_mask;
			busy <= next_busy;
			idx <= next_idx;
			pcnt <= next_pcnt;
		end
	end
	// page buffer and array writes, one buffered byte per clock
	always_ff @(posedge clk_sys)
	begin
		if (buf_we)
			pbuf[ptr[PAGE_W-1:0]] <= sh;
		if (busy && !idx[PAGE_W] && mask[idx[PAGE_W-1:0]])
			mem[{ptr[ADDR_W-1:PAGE_W], idx[PAGE_W-1:0]}] <= pbuf[idx[PAGE_W-1:0]];
	end
	assign bus.sda_s_out = 1'b0;
	assign bus.sda_s_oe = oe;
endmodule : see_eeprom
`default_nettype wire

// [src/see_fifo.sv]
`timescale 1ns/1ns
`default_nettype none
module see_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 16
) (
	input wire logic clk_sys,
	input wire logic rst_b,
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [WIDTH-1:0] in_data,
	output logic out_valid,
	input wire logic out_ready,
	output logic [WIDTH-1:0] out_data
);
	localparam int PW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem [DEPTH];
	logic [PW:0] wptr, rptr, next_wptr, next_rptr;
	logic push, pop;

	// ----------------------------------------------------------------
	// flags and pointers
	// ----------------------------------------------------------------
	always_comb
	begin
		in_ready = (wptr ^ rptr) != {1'b1, {PW{1'b0}}}; // not full
		out_valid = wptr != rptr; // not empty
		push = in_valid & in_ready;
		pop = out_valid & out_ready;
		next_wptr = push ? wptr + 1'b1 : wptr;
		next_rptr = pop ? rptr + 1'b1 : rptr;
		out_data = mem[rptr[PW-1:0]];
	end

	always_ff @(posedge clk_sys or negedge rst_b)
	begin
		if (!rst_b)
		begin
			wptr <= '0;
			rptr <= '0;
		end
		else
		begin
			wptr <= next_wptr;
			rptr <= next_rptr;
		end
	end

	// storage
	always_ff @(posedge clk_sys)
	begin
		if (push)
			mem[wptr[PW-1:0]] <= in_data;
	end
endmodule : see_fifo
`default_nettype wire

// [src/see_i2c_if.sv]
`timescale 1ns/1ns
`default_nettype none
interface see_i2c_if;
	logic scl;
	logic sda_m_out;
	logic sda_m_oe;
	logic sda_s_out;
	logic sda_s_oe;
	logic sda;

	// open-drain wire with pull-up
	assign sda = ~((sda_m_oe & ~sda_m_out) | (sda_s_oe & ~sda_s_out));

	modport master (output scl, output sda_m_out, output sda_m_oe, input sda);
	modport slave (input scl, input sda, output sda_s_out, output sda_s_oe);
endinterface : see_i2c_if
`default_nettype wire

// [src/see_master.sv]
`timescale 1ns/1ns
`default_nettype none
module see_master (
	input wire logic clk_sys,
	input wire logic rst_b,
	see_i2c_if.master bus,
	input wire logic cmd_valid,
	output logic cmd_ready,
	input wire see_pkg::see_cmd_type cmd_kind,
	input wire logic [see_pkg::ADDR_W-1:0] cmd_addr,
	input wire logic [4:0] cmd_len,
	input wire logic wr_valid,
	output logic wr_ready,
	input wire logic [7:0] wr_data,
	output logic rd_valid,
	output logic [7:0] rd_data,
	output logic done,
	output logic nacked
);
	import see_pkg::*;

	typedef enum logic [4:0] {
		HS_IDLE = 5'h01,
		HS_START = 5'h02,
		HS_TX = 5'h04,
		HS_RX = 5'h08,
		HS_STOP = 5'h10
	} see_hstate_type;

	see_hstate_type state, next_state;
	see_cmd_type kind, next_kind;
	logic [ADDR_W-1:0] addr, next_addr;
	logic [4:0] left, next_left;
	logic [2:0] step, next_step;
	logic [7:0] sh, next_sh, next_rd_data, f_data;
	logic [3:0] bitn, next_bitn;
	logic [6:0] qcnt, next_qcnt;
	logic [1:0] phase, next_phase;
	logic scl, next_scl, oe, next_oe, ackbad, next_ackbad;
	logic next_rd_valid, next_done, next_nacked, f_valid, pop;
	logic [1:0] sync1, sync2;
	logic tick;

	// write data buffer between user and serial engine
	see_fifo #(.WIDTH(FIFO_W), .DEPTH(FIFO_D)) u_fifo (
		.clk_sys(clk_sys),
		.rst_b(rst_b),
		.in_valid(wr_valid),
		.in_ready(wr_ready),
		.in_data(wr_data),
		.out_valid(f_valid),
		.out_ready(pop),
		.out_data(f_data)
	);

	// ----------------------------------------------------------------
	// data line synchroniser
	// ----------------------------------------------------------------
	always_ff @(posedge clk_sys or negedge rst_b)
	begin
		if (!rst_b)
		begin
			sync1 <= 2'h3;
			sync2 <= 2'h3;
		end
		else
		begin
			sync1 <= {sync1[0], bus.sda};
			sync2 <= {sync2[0], sync1[1]};
		end
	end

	// ----------------------------------------------------------------
	// quarter-period sequencer: P0 clock low, P1..P3 clock high
	// ----------------------------------------------------------------
	always_comb
	begin
		tick = qcnt == QTR_LAST;
		next_state = state;
		next_kind = kind;
		next_addr = addr;
		next_left = left;
		next_step = step;
		next_sh = sh;
		next_bitn = bitn;
		next_qcnt = tick ? 7'h00 : qcnt + 7'h01;
		next_phase = tick ? phase + 2'h1 : phase;
		next_scl = scl;
		next_oe = oe;
		next_ackbad = ackbad;
		next_rd_data = rd_data;
		next_rd_valid = 1'b0;
		next_done = 1'b0;
		next_nacked = nacked;
		pop = 1'b0;
		cmd_ready = state == HS_IDLE;
		if (state == HS_IDLE)
		begin
			next_qcnt = 7'h00;
			next_phase = 2'h0;
			next_scl = 1'b1;
			next_oe = 1'b0;
			if (cmd_valid)
			begin
				next_state = HS_START;
				next_kind = cmd_kind;
				next_addr = cmd_addr;
				next_left = cmd_len;
				next_nacked = 1'b0;
				next_scl = 1'b0;
				next_step = (cmd_kind == SEE_CMD_CUR) ? STEP_SAR : STEP_SAW;
			end
		end
		else if (tick)
		begin
			case (phase)
				2'h0: next_scl = 1'b1;
				2'h1:
				begin
					if (state == HS_START)
						next_oe = 1'b1;
					else if (state == HS_STOP)
						next_oe = 1'b0;
					else if (bitn == BYTE_BITS)
						next_ackbad = sync2[1];
					else if (state == HS_RX)
						next_sh = {sh[6:0], sync2[1]};
				end
				2'h3:
				begin
					next_scl = 1'b0;
					next_bitn = bitn + 4'h1;
					case (state)
						HS_START:
						begin
							next_state = HS_TX;
							next_bitn = 4'h0;
							next_sh = see_saddr(addr[ADDR_W-1 -: SA_HI_W], step == STEP_SAR);
						end
						HS_STOP:
						begin
							next_state = HS_IDLE;
							next_scl = 1'b1;
							next_done = 1'b1;
						end
						HS_TX:
						begin
							if (bitn != BYTE_BITS)
								next_sh = {sh[6:0], 1'b0};
							else
							begin
								next_bitn = 4'h0;
								if (ackbad)
								begin
									next_state = HS_STOP;
									next_nacked = 1'b1;
								end
								else if (step == STEP_SAW)
								begin
									next_state = (kind == SEE_CMD_POLL) ? HS_STOP : HS_TX;
									next_step = STEP_WAD;
									next_sh = addr[7:0];
								end
								else if (step == STEP_SAR)
								begin
									next_state = HS_RX;
									next_step = STEP_RDT;
								end
								else if (kind == SEE_CMD_RAND)
								begin
									next_state = HS_START;
									next_step = STEP_SAR;
								end
								else if (step == STEP_WDT && left == 5'h01)
									next_state = HS_STOP;
								else if (f_valid)
								begin
									pop = 1'b1;
									next_sh = f_data;
									next_step = STEP_WDT;
									if (step == STEP_WDT)
										next_left = left - 5'h01;
								end
								else
								begin
									// hold the clock high until data arrives
									next_scl = 1'b1;
									next_bitn = bitn;
									next_qcnt = qcnt;
									next_phase = phase;
								end
							end
						end
						default:
						begin
							if (bitn == 4'h7)
							begin
								next_rd_data = sh;
								next_rd_valid = 1'b1;
							end
							if (bitn == BYTE_BITS)
							begin
								next_bitn = 4'h0;
								next_left = left - 5'h01;
								if (left == 5'h01)
									next_state = HS_STOP;
							end
						end
					endcase
					// drive for the next unit
					if (next_state == HS_STOP)
						next_oe = 1'b1;
					else if (next_state == HS_START)
						next_oe = 1'b0;
					else if (next_state == HS_TX)
						next_oe = (next_bitn != BYTE_BITS) && !next_sh[7];
					else if (next_state == HS_RX)
						next_oe = (next_bitn == BYTE_BITS) && (left != 5'h01);
				end
				default: next_scl = scl;
			endcase
		end
	end

	always_ff @(posedge clk_sys or negedge rst_b)
	begin
		if (!rst_b)
		begin
			state <= HS_IDLE;
			kind <= SEE_CMD_WRITE;
			addr <= '0;
			left <= 5'h00;
			step <= STEP_SAW;
			sh <= 8'h00;
			bitn <= 4'h0;
			qcnt <= 7'h00;
			phase <= 2'h0;
			scl <= 1'b1;
			oe <= 1'b0;
			ackbad <= 1'b0;
			rd_data <= 8'h00;
			rd_valid <= 1'b0;
			done <= 1'b0;
			nacked <= 1'b0;
		end
		else
		begin
			state <= next_state;
			kind <= next_kind;
			addr <= next_addr;
			left <= next_left;
			step <= next_step;
			sh <= next_sh;
			bitn <= next_bitn;
			qcnt <= next_qcnt;
			phase <= next_phase;
			scl <= next_scl;
			oe <= next_oe;
			ackbad <= next_ackbad;
			rd_data <= next_rd_data;
			rd_valid <= next_rd_valid;
			done <= next_done;
			nacked <= next_nacked;
		end
	end

	assign bus.scl = scl;
	assign bus.sda_m_out = 1'b0;
	assign bus.sda_m_oe = oe;
endmodule : see_master
`default_nettype wire

// [src/see_pkg.sv]
package see_pkg;
	// ----------------------------------------------------------------
	// array geometry and slave address layout
	// ----------------------------------------------------------------
	localparam int ADDR_W = 11;
	localparam int MEM_DEPTH = 2048;
	localparam int PAGE_W = 4;
	localparam logic [3:0] DEV_TYPE = 4'h6; // arbitrary device-type code
	localparam int SA_TYPE_LSB = 4;
	localparam int SA_HI_LSB = 1;
	localparam int SA_RW_BIT = 0;
	localparam int SA_HI_W = 3;
	localparam logic [3:0] BYTE_BITS = 4'h8;
	localparam logic [1:0] KIND_SADDR = 2'h0;
	localparam logic [1:0] KIND_WADDR = 2'h1;
	localparam logic [1:0] KIND_DATA = 2'h2;

	// ----------------------------------------------------------------
	// timing
	// ----------------------------------------------------------------
	localparam int CLK_NS = 8;
	localparam int T_WR_US = 5; // internal programming time
	localparam int WR_CYC = T_WR_US * 1000 / CLK_NS;
	localparam logic [9:0] WR_LAST = 10'(WR_CYC - 1);
	localparam int T_SCL_NS = 2500; // serial clock period made by the master
	localparam int QTR_CYC = (T_SCL_NS / 4 + CLK_NS - 1) / CLK_NS;
	localparam logic [6:0] QTR_LAST = 7'(QTR_CYC - 1);

	// ----------------------------------------------------------------
	// master commands and byte roles
	// ----------------------------------------------------------------
	localparam int FIFO_W = 8;
	localparam int FIFO_D = 16;
	typedef enum logic [1:0] {
		SEE_CMD_WRITE = 2'h0,
		SEE_CMD_RAND = 2'h1,
		SEE_CMD_CUR = 2'h2,
		SEE_CMD_POLL = 2'h3
	} see_cmd_type;
	localparam logic [2:0] STEP_SAW = 3'h0;
	localparam logic [2:0] STEP_WAD = 3'h1;
	localparam logic [2:0] STEP_WDT = 3'h2;
	localparam logic [2:0] STEP_SAR = 3'h3;
	localparam logic [2:0] STEP_RDT = 3'h4;

	// slave address byte from high address bits and direction
	function automatic logic [7:0] see_saddr(input logic [2:0] hi, input logic rd);
		return {DEV_TYPE, hi, rd};
	endfunction : see_saddr
endpackage : see_pkg

// [tb/see_asserts.sv]
`timescale 1ns/1ns
`default_nettype none
module see_asserts (
	input wire logic clk_sys,
	input wire logic rst_b,
	input wire logic scl,
	input wire logic sda_m_oe,
	input wire logic sda_s_oe,
	input wire logic sda,
	input wire logic busy,
	input wire logic wp
);
	import see_pkg::*;
	// ----------------------------------------------------------------
	// bus tracking
	// ----------------------------------------------------------------
	logic scl_q, sda_q, rd, bz, rise, st, ack_due;
	logic [3:0] idx;
	logic [4:0] nb;
	logic [7:0] sh;
	logic [9:0] bcnt;
	// edge and condition decode on sampled lines
	assign rise = scl && !scl_q;
	assign st = scl && scl_q && sda_q && !sda;
	assign ack_due = (nb == 5'h00 && sh[7:4] == DEV_TYPE) || (!rd && nb != 5'h00 && (nb == 5'h01 || !wp));
	// bit, byte, direction and busy-at-start tracking
	always_ff @(posedge clk_sys or negedge rst_b)
	begin
		if (!rst_b)
		begin
			{scl_q, sda_q, rd, bz, idx, nb, sh, bcnt} <= {2'h3, 2'h0, 4'h0, 5'h00, 8'h00, 10'h000};
		end
		else
		begin
			scl_q <= scl;
			sda_q <= sda;
			bcnt <= busy ? bcnt + 10'h001 : 10'h000;
			if (st)
			begin
				{idx, nb, rd, bz} <= {4'h0, 5'h00, 1'b0, busy};
			end
			else
			begin
				if (busy)
					bz <= 1'b1;
				if (rise)
				begin
					idx <= (idx == 4'h8) ? 4'h0 : idx + 4'h1;
					sh <= {sh[6:0], sda};
					if (idx == 4'h8 && nb != 5'h1F)
						nb <= nb + 5'h01;
					if (idx == 4'h7 && nb == 5'h00)
						rd <= sda;
				end
			end
		end
	end

	// ----------------------------------------------------------------
	// properties
	// ----------------------------------------------------------------
	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (!rst_b);

	busy_quiet_a: assert property (busy |-> !sda_s_oe)
		else $error("slave drove sda while programming");
	busy_len_a: assert property ($fell(busy) |-> bcnt == WR_CYC)
		else $error("programming time wrong");
	busy_cause_a: assert property ($rose(busy) |-> scl && sda && !rd && nb >= 5'h03)
		else $error("programming began without stop after data");
	no_contend_a: assert property (rise |-> !(sda_m_oe && sda_s_oe))
		else $error("both parties pulled sda at sampling");
	sda_hold_a: assert property (scl && $past(scl) |-> $stable(sda_s_oe))
		else $error("slave changed sda while scl high");
	write_quiet_a: assert property (rise && !rd && idx != 4'h8 |-> !sda_s_oe)
		else $error("slave drove a data bit in write mode");
	read_release_a: assert property (rise && rd && nb != 5'h00 && idx == 4'h8 |-> !sda_s_oe)
		else $error("slave held sda in master ack slot");
	wp_refuse_a: assert property (rise && idx == 4'h8 && !rd && nb == 5'h02 && wp |-> !sda_s_oe)
		else $error("protected data byte acknowledged");
	ack_give_a: assert property (rise && idx == 4'h8 && !bz && !busy && ack_due |-> sda_s_oe)
		else $error("expected acknowledge missing");

	// main scenarios reached
	cover property ($rose(busy));
	cover property (rise && idx == 4'h8 && bz && !sda_s_oe);
	cover property (rise && idx == 4'h8 && rd && nb != 5'h00 && !sda_m_oe);
endmodule : see_asserts
`default_nettype wire

// [tb/serial_eeprom_bus_slave_tb.sv]
`timescale 1ns/1ns
`default_nettype none
module serial_eeprom_bus_slave_tb;
	import see_pkg::*;
	// ----------------------------------------------------------------
	// bench signals and instances
	// ----------------------------------------------------------------
	logic clk_sys, rst_b, wp, cmd_valid, cmd_ready, wr_valid, wr_ready;
	logic rd_valid, done, nacked, busy;
	see_cmd_type cmd_kind;
	logic [ADDR_W-1:0] cmd_addr;
	logic [4:0] cmd_len;
	logic [7:0] wr_data, rd_data;
	logic [7:0] rxq[$];
	int error_cnt, checked;

	see_i2c_if i_see_i2c_if ();
	see_eeprom i_see_eeprom (.clk_sys(clk_sys), .rst_b(rst_b), .wp(wp), .bus(i_see_i2c_if),
		.busy(busy));
	see_master i_see_master (.clk_sys(clk_sys), .rst_b(rst_b), .bus(i_see_i2c_if),
		.cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd_kind(cmd_kind), .cmd_addr(cmd_addr),
		.cmd_len(cmd_len), .wr_valid(wr_valid), .wr_ready(wr_ready), .wr_data(wr_data),
		.rd_valid(rd_valid), .rd_data(rd_data), .done(done), .nacked(nacked));
	see_asserts i_see_asserts (.clk_sys(clk_sys), .rst_b(rst_b), .scl(i_see_i2c_if.scl),
		.sda_m_oe(i_see_i2c_if.sda_m_oe), .sda_s_oe(i_see_i2c_if.sda_s_oe),
		.sda(i_see_i2c_if.sda), .busy(busy), .wp(wp));

	// free-running system clock
	always #4 clk_sys = ~clk_sys;

	// ----------------------------------------------------------------
	// shared tasks
	// ----------------------------------------------------------------
	function automatic logic [7:0] pd(input int k);
		return 8'(8'h40 + k);
	endfunction : pd

	task report_and_stop();
		if (error_cnt == 0 && checked > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask : report_and_stop

	task chk(input logic [7:0] got, input logic [7:0] exp);
		checked++;
		if (got !== exp)
		begin
			error_cnt++;
			$display("[ERR] %0t seen %h expected %h", $time, got, exp);
		end
	endtask : chk

	task tout();
		error_cnt++;
		$display("[ERR] %0t wait limit ran out", $time);
		report_and_stop();
	endtask : tout

	// hold valid and step data on each accepting edge
	task fill(input int n, input logic [7:0] b0);
		int k;
		logic acc;
		k = 0;
		wr_valid <= 1'b1;
		wr_data <= b0;
		repeat (64)
		begin
			@(negedge clk_sys);
			acc = wr_ready;
			@(posedge clk_sys);
			if (acc)
				k++;
			wr_data <= 8'(b0 + k);
			if (k == n)
				break;
		end
		wr_valid <= 1'b0;
		if (k != n)
			tout();
	endtask : fill

	// issue one command, gather read bytes until done
	task cmd(input see_cmd_type kind, input logic [ADDR_W-1:0] addr, input logic [4:0] len);
		logic acc;
		int i;
		rxq.delete();
		acc = 1'b0;
		cmd_valid <= 1'b1;
		cmd_kind <= kind;
		cmd_addr <= addr;
		cmd_len <= len;
		for (i = 0; i < 8 && !acc; i++)
		begin
			@(negedge clk_sys);
			acc = cmd_ready;
			@(posedge clk_sys);
		end
		cmd_valid <= 1'b0;
		if (!acc)
			tout();
		for (i = 0; i < 60000; i++)
		begin
			@(negedge clk_sys);
			if (rd_valid === 1'b1)
				rxq.push_back(rd_data);
			if (done === 1'b1)
				break;
		end
		if (i == 60000)
			tout();
		@(posedge clk_sys);
	endtask : cmd

	task wait_busy(input logic val, input int n);
		int i;
		@(negedge clk_sys);
		for (i = 0; i < n && busy !== val; i++)
			@(negedge clk_sys);
		chk({7'h00, busy}, {7'h00, val});
		if (busy !== val)
			tout();
		@(posedge clk_sys);
	endtask : wait_busy

	// ----------------------------------------------------------------
	// scenarios
	// ----------------------------------------------------------------
	// full buffer, page write starting mid-page, then polling
	task sc_page();
		fill(16, pd(0));
		@(negedge clk_sys);
		chk({7'h00, wr_ready}, 8'h00);
		@(posedge clk_sys);
		cmd(SEE_CMD_WRITE, 11'h005, 5'h10);
		chk({7'h00, nacked}, 8'h00);
		wait_busy(1'b1, 16);
		cmd(SEE_CMD_POLL, 11'h000, 5'h01);
		chk({7'h00, nacked}, 8'h01);
		cmd(SEE_CMD_POLL, 11'h000, 5'h01);
		chk({7'h00, nacked}, 8'h00);
	endtask : sc_page

	// single byte at the top address
	task sc_top();
		fill(1, 8'hE7);
		cmd(SEE_CMD_WRITE, 11'h7FF, 5'h01);
		chk({7'h00, nacked}, 8'h00);
		wait_busy(1'b1, 16);
		wait_busy(1'b0, 700);
	endtask : sc_top

	// protected write is refused and never programs
	task sc_wp();
		wp <= 1'b1;
		fill(1, 8'h5A);
		cmd(SEE_CMD_WRITE, 11'h003, 5'h01);
		chk({7'h00, nacked}, 8'h01);
		repeat (30) @(negedge clk_sys);
		chk({7'h00, busy}, 8'h00);
		@(posedge clk_sys);
		wp <= 1'b0;
	endtask : sc_wp

	// random read across the top, through the wrapped page
	task sc_rand();
		int i;
		cmd(SEE_CMD_RAND, 11'h7FF, 5'h05);
		chk(8'(rxq.size()), 8'h05);
		for (i = 0; i < 5; i++)
			chk(rxq[i], (i == 0) ? 8'hE7 : pd(10 + i));
	endtask : sc_rand

	// current read continues after the last byte read
	task sc_cur();
		cmd(SEE_CMD_CUR, 11'h000, 5'h01);
		chk(8'(rxq.size()), 8'h01);
		chk(rxq[0], pd(15));
	endtask : sc_cur

	// ----------------------------------------------------------------
	// main sequence
	// ----------------------------------------------------------------
	initial
	begin
		clk_sys = 1'b0;
		rst_b = 1'b0;
		wp = 1'b0;
		cmd_valid = 1'b0;
		cmd_kind = SEE_CMD_WRITE;
		cmd_addr = 11'h000;
		cmd_len = 5'h01;
		wr_valid = 1'b0;
		wr_data = 8'h00;
		error_cnt = 0;
		checked = 0;
		repeat (16) @(posedge clk_sys);
		chk({6'h00, cmd_ready, busy}, 8'h02);
		rst_b <= 1'b1;
		@(posedge clk_sys);
		sc_page();
		sc_top();
		sc_wp();
		sc_rand();
		sc_cur();
		report_and_stop();
	end
endmodule : serial_eeprom_bus_slave_tb
`default_nettype wire
